// ==== hw/fed_flight_event_detector.sv ====
`timescale 1ns/100ps
module fed_flight_event_detector
  import fed_pkg::*;
#(
  parameter logic [ACC_W-1:0] ZERO_TOL_MG = 16'h0000 // band counted as zero
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flight_strap, // stored boot choice, asynchronous pin
  input wire fed_press_type press_in, // same-clock sensor front end
  input wire fed_accel_type accel_in, // same-clock sensor front end
  input wire fed_axi_req_type axi_req,
  output fed_axi_rsp_type axi_rsp,
  output fed_events_type events,
  output fed_mode_type mode,
  output logic flight_next_sel, // to be kept for the next power-up
  output logic avg_valid,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] strap_sync; // two-stage strap synchroniser
    logic [1:0] settle; // wait for the synchroniser to fill
    logic booted;
    fed_mode_type mode;
    logic [AVG_DEPTH-1:0][PRESS_W-1:0] win; // pressure window
    logic [FILL_W-1:0] fill; // samples seen, saturating
    logic avg_ok;
    logic avg_upd; // new mean this cycle
    logic alt_upd; // new altitude this cycle
    logic [PRESS_W-1:0] avg;
    logic [PRESS_W-1:0] min_p;
    logic min_set;
    logic [APO_CNT_W-1:0] apo_cnt;
    logic signed [ALT_W-1:0] alt;
    logic signed [ALT_W-1:0] peak;
    fed_events_type ev;
    logic desc;
    logic late;
    logic flight_next;
    logic signed [ALT_W-1:0] thr;
    logic [PRESS_W-1:0] ref_p;
    logic [SCALE_W-1:0] scale;
    logic [EV_N-1:0] int_stat;
    logic [EV_N-1:0] int_mask;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fed_state_type;

  fed_state_type s_reg; // registered state
  fed_state_type s_next; // next state

  // ==========================================================
  // functions

  // mean of the window
  function automatic logic [PRESS_W-1:0] win_mean(
    input logic [AVG_DEPTH-1:0][PRESS_W-1:0] w
  );
    logic [PRESS_W+FILL_W-1:0] sum;
    sum = '0;
    for (int i = 0; i < AVG_DEPTH; i++) begin
      sum = sum + (PRESS_W+FILL_W)'(w[i]);
    end
    return PRESS_W'(sum / (PRESS_W+FILL_W)'(AVG_DEPTH));
  endfunction

  // linear conversion around the reference pressure
  function automatic logic signed [ALT_W-1:0] alt_of(
    input logic [PRESS_W-1:0] p,
    input logic [PRESS_W-1:0] ref_p,
    input logic [SCALE_W-1:0] scale
  );
    logic signed [PRESS_W:0] diff;
    logic signed [PRESS_W+SCALE_W+1:0] prod;
    diff = $signed({1'b0, ref_p}) - $signed({1'b0, p});
    prod = diff * $signed({1'b0, scale});
    return ALT_W'(prod >>> SCALE_SHIFT);
  endfunction

  // magnitude within the zero band
  function automatic logic near_zero(input logic signed [ACC_W-1:0] a);
    logic [ACC_W-1:0] mag;
    mag = a[ACC_W-1] ? ACC_W'(-a) : ACC_W'(a);
    return mag <= ZERO_TOL_MG;
  endfunction

  // offset belongs to the register map
  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    unique case (a)
      OFS_CTRL, OFS_ALT_THRESH, OFS_ALT_REF, OFS_ALT_SCALE, OFS_STATUS,
      OFS_AVG_PRESS, OFS_ALTITUDE, OFS_MIN_PRESS, OFS_INT_STAT,
      OFS_INT_MASK, OFS_PEAK_ALT, OFS_APO_CNT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic flight;
    logic [FILL_W-1:0] fill_n;
    logic [31:0] ctrl_w;
    logic [31:0] wv;
    logic [EV_N-1:0] w1c;
    fed_events_type hit;
    logic [31:0] rd;
    logic cfg_open; // configuration may still change
    flight = 1'b0;
    fill_n = '0;
    ctrl_w = '0;
    wv = '0;
    w1c = '0;
    hit = '0;
    rd = '0;
    cfg_open = 1'b0;
    s_next = s_reg;
    s_next.avg_upd = 1'b0;
    s_next.alt_upd = 1'b0;
    flight = (s_reg.mode == FED_FLIGHT);
    // reset wipes the setup, so a flight is armed on the pad before launch
    cfg_open = !flight || !s_reg.ev.launch;

    // strap capture once the synchroniser has settled
    s_next.strap_sync = {s_reg.strap_sync[0], flight_strap};
    if (!s_reg.booted) begin
      if (s_reg.settle == BOOT_SETTLE) begin
        s_next.booted = 1'b1;
        s_next.mode = s_reg.strap_sync[1] ? FED_FLIGHT : FED_IDLE;
      end else begin
        s_next.settle = s_reg.settle + 2'h1;
      end
    end

    // sliding window and its mean
    if (press_in.valid) begin
      s_next.win = {s_reg.win[AVG_DEPTH-2:0], press_in.value};
      fill_n = (s_reg.fill == FILL_W'(AVG_DEPTH)) ? s_reg.fill : s_reg.fill + 3'h1;
      s_next.fill = fill_n;
      s_next.avg = win_mean(s_next.win);
      s_next.avg_upd = 1'b1;
      if (fill_n == FILL_W'(AVG_DEPTH)) begin
        s_next.avg_ok = 1'b1;
      end
    end

    // altitude on each valid mean, apogee search only in flight once launch is seen
    if (s_reg.avg_upd && s_reg.avg_ok) begin
      s_next.alt = alt_of(s_reg.avg, s_reg.ref_p, s_reg.scale);
      s_next.alt_upd = 1'b1;
      if (flight && s_reg.ev.launch) begin
        if (!s_reg.min_set || s_reg.avg < s_reg.min_p) begin
          s_next.min_p = s_reg.avg;
          s_next.min_set = 1'b1;
        end
        if (s_reg.min_set && s_reg.avg > s_reg.min_p &&
            (s_reg.avg - s_reg.min_p) > PRESS_TOL) begin
          if (s_reg.apo_cnt != APOGEE_HITS) begin
            s_next.apo_cnt = s_reg.apo_cnt + 4'h1;
          end
        end else begin
          s_next.apo_cnt = '0;
        end
        if (s_next.apo_cnt == APOGEE_HITS) begin
          hit.apogee = 1'b1;
        end
      end
    end

    // altitude-based events
    if (s_reg.alt_upd && flight) begin
      if (s_reg.alt > s_reg.peak) begin
        s_next.peak = s_reg.alt;
      end
      if (s_reg.desc) begin
        hit.alt_reached = s_reg.ev.apogee && (s_reg.alt < s_reg.thr);
      end else begin
        hit.alt_reached = !s_reg.ev.apogee && (s_reg.alt > s_reg.thr);
      end
      if (s_reg.late && s_reg.ev.apogee && s_reg.alt < LAND_ALT_FT) begin
        hit.landing = 1'b1;
      end
    end

    // acceleration-based events
    if (accel_in.valid && flight) begin
      if (accel_in.y >= LAUNCH_MG) begin
        hit.launch = 1'b1;
      end
      if (s_reg.ev.launch && near_zero(accel_in.x) && near_zero(accel_in.y) &&
          near_zero(accel_in.z)) begin
        hit.burnout = 1'b1;
      end
      if (!s_reg.late && s_reg.ev.apogee && near_zero(accel_in.cx) &&
          near_zero(accel_in.cy) && near_zero(accel_in.cz)) begin
        hit.landing = 1'b1;
      end
    end

    // sticky flags, only ever set
    s_next.ev = s_reg.ev | hit;

    // bus write: address and data taken in either order
    if (axi_req.awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.waddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_reg.waddr)
        // configuration takes writes until launch is seen
        OFS_CTRL: begin
          ctrl_w = '0;
          ctrl_w[CTRL_DESC_BIT] = s_reg.desc;
          ctrl_w[CTRL_LATE_BIT] = s_reg.late;
          ctrl_w[CTRL_FLIGHT_BIT] = s_reg.flight_next;
          wv = merge(ctrl_w, s_reg.wdata, s_reg.wstrb);
          if (cfg_open) begin
            s_next.desc = wv[CTRL_DESC_BIT];
            s_next.late = wv[CTRL_LATE_BIT];
            s_next.flight_next = wv[CTRL_FLIGHT_BIT];
          end
        end
        OFS_ALT_THRESH: begin
          wv = merge(32'(s_reg.thr), s_reg.wdata, s_reg.wstrb);
          if (cfg_open) begin
            s_next.thr = ALT_W'(wv);
          end
        end
        OFS_ALT_REF: begin
          wv = merge(32'(s_reg.ref_p), s_reg.wdata, s_reg.wstrb);
          if (cfg_open) begin
            s_next.ref_p = PRESS_W'(wv);
          end
        end
        OFS_ALT_SCALE: begin
          wv = merge(32'(s_reg.scale), s_reg.wdata, s_reg.wstrb);
          if (cfg_open) begin
            s_next.scale = SCALE_W'(wv);
          end
        end
        // interrupt bits clear on a written one
        OFS_INT_STAT: begin
          wv = merge(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
          w1c = EV_N'(wv);
        end
        OFS_INT_MASK: begin
          wv = merge(32'(s_reg.int_mask), s_reg.wdata, s_reg.wstrb);
          s_next.int_mask = EV_N'(wv);
        end
        // read-only and unmapped offsets change nothing
        default: begin
          wv = '0;
        end
      endcase
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // interrupt status: a new event beats a clear
    s_next.int_stat = (s_reg.int_stat & ~w1c) | (s_next.ev & ~s_reg.ev);
    s_next.irq = |(s_next.int_stat & s_next.int_mask);

    // bus read
    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_reg.arready) begin
      unique case (axi_req.araddr)
        OFS_CTRL: begin
          rd[CTRL_DESC_BIT] = s_reg.desc;
          rd[CTRL_LATE_BIT] = s_reg.late;
          rd[CTRL_FLIGHT_BIT] = s_reg.flight_next;
        end
        OFS_ALT_THRESH: rd = 32'(s_reg.thr);
        OFS_ALT_REF: rd = 32'(s_reg.ref_p);
        OFS_ALT_SCALE: rd = 32'(s_reg.scale);
        OFS_STATUS: begin
          rd[ST_FLIGHT_BIT] = flight;
          rd[ST_AVG_OK_BIT] = s_reg.avg_ok;
          rd[ST_BOOTED_BIT] = s_reg.booted;
          rd[ST_EV_LSB +: EV_N] = s_reg.ev;
        end
        OFS_AVG_PRESS: rd = 32'(s_reg.avg);
        OFS_ALTITUDE: rd = 32'(s_reg.alt);
        OFS_MIN_PRESS: rd = 32'(s_reg.min_p);
        OFS_INT_STAT: rd = 32'(s_reg.int_stat);
        OFS_INT_MASK: rd = 32'(s_reg.int_mask);
        OFS_PEAK_ALT: rd = 32'(s_reg.peak);
        OFS_APO_CNT: rd = 32'(s_reg.apo_cnt);
        default: rd = '0; // unmapped reads zero
      endcase
      s_next.rdata = rd;
      s_next.rresp = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      s_next.rvalid = 1'b1;
    end
    s_next.arready = !s_next.rvalid;
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.mode <= FED_IDLE;
      s_reg.ref_p <= ALT_REF_RST;
      s_reg.scale <= SCALE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign axi_rsp.awready = s_reg.awready;
  assign axi_rsp.wready = s_reg.wready;
  assign axi_rsp.bvalid = s_reg.bvalid;
  assign axi_rsp.bresp = s_reg.bresp;
  assign axi_rsp.arready = s_reg.arready;
  assign axi_rsp.rvalid = s_reg.rvalid;
  assign axi_rsp.rdata = s_reg.rdata;
  assign axi_rsp.rresp = s_reg.rresp;
  assign events = s_reg.ev;
  assign mode = s_reg.mode;
  assign flight_next_sel = s_reg.flight_next;
  assign avg_valid = s_reg.avg_ok;
  assign irq = s_reg.irq;

endmodule

// ==== hw/fed_pkg.sv ====
package fed_pkg;
  // ==========================================================
  // widths and counts
  localparam int PRESS_W = 24; // pressure, 0.01 hPa per lsb
  localparam int ACC_W = 16; // acceleration, signed mg
  localparam int ALT_W = 24; // altitude, signed feet
  localparam int SCALE_W = 16; // feet per lsb, 8 fraction bits
  localparam int SCALE_SHIFT = 8; // fraction bits of the scale
  localparam int AVG_DEPTH = 5; // samples in the pressure mean
  localparam int FILL_W = 3; // counts up to AVG_DEPTH
  localparam int APO_CNT_W = 4; // apogee counter width
  localparam logic [APO_CNT_W-1:0] APOGEE_HITS = 4'h5; // ticks to apogee
  localparam logic [1:0] BOOT_SETTLE = 2'h3; // cycles before strap capture
  localparam int EV_N = 5; // number of flight events

  // ==========================================================
  // thresholds
  localparam logic [PRESS_W-1:0] PRESS_TOL = 24'h00_000a; // 0.1 hPa
  localparam logic signed [ACC_W-1:0] LAUNCH_MG = 16'h05dc; // 1.5 g
  localparam logic signed [ALT_W-1:0] LAND_ALT_FT = 24'h00_000a; // 10 ft

  // ==========================================================
  // register map, byte offsets
  localparam int AXI_ADDR_W = 12;
  localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [AXI_ADDR_W-1:0] OFS_ALT_THRESH = 12'h004;
  localparam logic [AXI_ADDR_W-1:0] OFS_ALT_REF = 12'h008;
  localparam logic [AXI_ADDR_W-1:0] OFS_ALT_SCALE = 12'h00c;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [AXI_ADDR_W-1:0] OFS_AVG_PRESS = 12'h014;
  localparam logic [AXI_ADDR_W-1:0] OFS_ALTITUDE = 12'h018;
  localparam logic [AXI_ADDR_W-1:0] OFS_MIN_PRESS = 12'h01c;
  localparam logic [AXI_ADDR_W-1:0] OFS_INT_STAT = 12'h020;
  localparam logic [AXI_ADDR_W-1:0] OFS_INT_MASK = 12'h024;
  localparam logic [AXI_ADDR_W-1:0] OFS_PEAK_ALT = 12'h028;
  localparam logic [AXI_ADDR_W-1:0] OFS_APO_CNT = 12'h02c;

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_DESC_BIT = 0; // altitude event on the way down
  localparam int CTRL_LATE_BIT = 1; // landing by altitude
  localparam int CTRL_FLIGHT_BIT = 2; // boot into flight next time
  localparam int ST_FLIGHT_BIT = 0;
  localparam int ST_AVG_OK_BIT = 1;
  localparam int ST_BOOTED_BIT = 2;
  localparam int ST_EV_LSB = 8;
  localparam logic [PRESS_W-1:0] ALT_REF_RST = 24'h01_8bcd; // 1013.25 hPa
  localparam logic [SCALE_W-1:0] SCALE_RST = 16'h0046; // about 0.27 ft
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic {FED_IDLE, FED_FLIGHT} fed_mode_type;

  typedef struct packed {
    logic landing;
    logic alt_reached;
    logic apogee;
    logic burnout;
    logic launch;
  } fed_events_type;

  typedef struct packed {
    logic valid;
    logic [PRESS_W-1:0] value;
  } fed_press_type;

  typedef struct packed {
    logic valid;
    logic signed [ACC_W-1:0] x, y, z; // raw, gravity included
    logic signed [ACC_W-1:0] cx, cy, cz; // gravity removed
  } fed_accel_type;

  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } fed_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fed_axi_rsp_type;
endpackage

// ==== bench/fed_sensor_model.sv ====
`timescale 1ns/100ps
// ==========================================
// sensor stand-in: pressure and inertial samples
module fed_sensor_model
  import fed_pkg::*;
(
  input wire logic mclk,
  output fed_press_type press_in,
  output fed_accel_type accel_in
);
  // lines quiet at start
  initial begin
    press_in = '0;
    accel_in = '0;
  end

  // one pressure pulse, then the line shows the inverse
  task automatic press(input logic [PRESS_W-1:0] v);
    @(posedge mclk);
    press_in <= '{1'b1, v};
    @(posedge mclk);
    press_in <= '{1'b0, ~v};
    repeat (4) @(posedge mclk);
  endtask

  // one inertial pulse: raw and gravity-free axes together, then the inverse
  task automatic accel(input logic [ACC_W-1:0] x, y, z, cx, cy, cz);
    @(posedge mclk);
    accel_in <= '{1'b1, x, y, z, cx, cy, cz};
    @(posedge mclk);
    accel_in <= '{1'b0, ~x, ~y, ~z, ~cx, ~cy, ~cz};
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ==== bench/fed_checker_props.sv ====
`timescale 1ns/100ps
// ==========================================
// port checker for the event detector
module fed_checker
  import fed_pkg::*;
#(
  parameter logic [ACC_W-1:0] ZERO_TOL_MG = 16'h0000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flight_strap,
  input wire fed_press_type press_in,
  input wire fed_accel_type accel_in,
  input wire fed_axi_req_type axi_req,
  input wire fed_axi_rsp_type axi_rsp,
  input wire fed_events_type events,
  input wire fed_mode_type mode,
  input wire logic flight_next_sel,
  input wire logic avg_valid,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // pressure samples since reset, saturating
  logic [FILL_W-1:0] fill_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fill_reg <= '0;
    end else if (press_in.valid && fill_reg != FILL_W'(AVG_DEPTH)) begin
      fill_reg <= fill_reg + 1'b1;
    end
  end

  // axis inside the zero band
  function automatic logic near_zero(input logic signed [ACC_W-1:0] a);
    return (a <= $signed(ZERO_TOL_MG)) && (a >= -$signed(ZERO_TOL_MG));
  endfunction
  logic raw_still;
  assign raw_still = near_zero(accel_in.x) && near_zero(accel_in.y) && near_zero(accel_in.z);

  // ==========================================
  // sequences
  sequence s_liftoff;
    accel_in.valid && mode == FED_FLIGHT && accel_in.y >= LAUNCH_MG;
  endsequence
  sequence s_still;
    accel_in.valid && mode == FED_FLIGHT && events.launch && raw_still;
  endsequence

  // ==========================================
  // properties
  property p_launch_set;
    s_liftoff |=> events.launch;
  endproperty
  a_launch_set: assert property (p_launch_set) else $error("launch missed");
  property p_launch_cause;
    $rose(events.launch) |-> $past(accel_in.valid) && $past(accel_in.y) >= LAUNCH_MG;
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("launch unprompted");
  property p_burnout_set;
    s_still |=> events.burnout;
  endproperty
  a_burnout_set: assert property (p_burnout_set) else $error("burnout missed");
  property p_burnout_cause;
    $rose(events.burnout) |-> $past(accel_in.valid && raw_still);
  endproperty
  a_burnout_cause: assert property (p_burnout_cause) else $error("burnout unprompted");
  property p_sticky;
    events != '0 |=> (events & $past(events)) == $past(events);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped");
  property p_idle_quiet;
    mode == FED_IDLE |-> events == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("event in idle");
  property p_boot_idle;
    $rose(rst_b) |-> mode == FED_IDLE;
  endproperty
  a_boot_idle: assert property (p_boot_idle) else $error("not idle after reset");
  property p_mode_hold;
    mode == FED_FLIGHT |=> mode == FED_FLIGHT;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("flight mode left");
  property p_fill;
    avg_valid == (fill_reg == FILL_W'(AVG_DEPTH));
  endproperty
  a_fill: assert property (p_fill) else $error("average valid wrong");
  property p_apogee_gate;
    $rose(events.apogee) |-> events.launch && avg_valid;
  endproperty
  a_apogee_gate: assert property (p_apogee_gate) else $error("apogee too early");
  property p_apogee_press;
    $rose(events.apogee) |->
      $past(press_in.valid, 1) || $past(press_in.valid, 2) || $past(press_in.valid, 3);
  endproperty
  a_apogee_press: assert property (p_apogee_press) else $error("apogee not from pressure");
  property p_land_after;
    $rose(events.landing) |-> $past(events.apogee);
  endproperty
  a_land_after: assert property (p_land_after) else $error("landing before apogee");
  property p_read_answer;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
// ==========================================
// bench top: register master, sensors, verdict
module testbench
  import fed_pkg::*;
;
  logic mclk;
  logic rst_b;
  logic flight_strap;
  fed_press_type press_in;
  fed_accel_type accel_in;
  fed_axi_req_type axi_req;
  fed_axi_rsp_type axi_rsp;
  fed_events_type events;
  fed_mode_type mode;
  logic flight_next_sel;
  logic avg_valid;
  logic irq;
  int fail_count;
  int total_checks;
  logic [31:0] rd;
  logic [1:0] rs;

  fed_flight_event_detector dut (
    .mclk(mclk), .rst_b(rst_b), .flight_strap(flight_strap), .press_in(press_in),
    .accel_in(accel_in), .axi_req(axi_req), .axi_rsp(axi_rsp), .events(events),
    .mode(mode), .flight_next_sel(flight_next_sel), .avg_valid(avg_valid), .irq(irq)
  );
  fed_sensor_model sm (.mclk(mclk), .press_in(press_in), .accel_in(accel_in));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================
  // compare, verdict, hang cut-off
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic stall();
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask

  // ==========================================
  // register bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf);
    int n;
    n = 0;
    @(posedge mclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= st;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    rs = 2'h1;
    while (rs === 2'h1) begin
      @(posedge mclk);
      n++;
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) begin
        rs = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
      end
      if (n > 50) stall();
    end
    chk(32'(rs), 32'(RESP_OKAY));
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    rs = 2'h1;
    while (rs === 2'h1) begin
      @(posedge mclk);
      n++;
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) begin
        rs = axi_rsp.rresp;
        rd = axi_rsp.rdata;
        axi_req.rready <= 1'b0;
      end
      if (n > 50) stall();
    end
    chk(rd, exp);
    chk(32'(rs), 32'(er));
  endtask

  // reset for 20 cycles with the boot choice held
  task automatic boot(input logic strap);
    @(posedge mclk);
    rst_b <= 1'b0;
    flight_strap <= strap;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask

  // ==========================================
  // scenarios
  task automatic t_idle();
    chk(32'(mode), 32'(FED_IDLE));
    rdc(OFS_ALT_REF, 32'(ALT_REF_RST), RESP_OKAY);
    rdc(OFS_ALT_SCALE, 32'(SCALE_RST), RESP_OKAY);
    rdc(OFS_INT_MASK, 32'h0, RESP_OKAY);
    rdc(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
    rdc(12'h100, 32'h0, RESP_SLVERR);
    wr(OFS_ALT_THRESH, 32'h0000_1234);
    rdc(OFS_ALT_THRESH, 32'h0000_1234, RESP_OKAY);
    wr(OFS_ALT_THRESH, 32'h0000_56ff, 4'h1);
    rdc(OFS_ALT_THRESH, 32'h0000_12ff, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0004);
    chk(32'(flight_next_sel), 32'h1);
    sm.accel(16'h0000, 16'h0600, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk(32'(events), 32'h0);
  endtask
  task automatic t_launch();
    chk(32'(mode), 32'(FED_FLIGHT));
    wr(OFS_ALT_THRESH, 32'h0000_0100);
    rdc(OFS_ALT_THRESH, 32'h0000_0100, RESP_OKAY);
    wr(OFS_INT_MASK, 32'h0000_0001);
    for (int i = 0; i < 4; i++) sm.press(24'h01_86a0 + 24'(i));
    chk(32'(avg_valid), 32'h0);
    sm.press(24'h01_86a9);
    chk(32'(avg_valid), 32'h1);
    rdc(OFS_AVG_PRESS, 32'h0001_86a3, RESP_OKAY);
    rd = ((32'(ALT_REF_RST) - 32'h0001_86a3) * 32'(SCALE_RST)) >> SCALE_SHIFT;
    rdc(OFS_ALTITUDE, rd, RESP_OKAY);
    chk(32'(events.alt_reached), 32'h1);
    chk(32'(irq), 32'h0);
    sm.accel(16'h0000, 16'h05db, 16'h0000, 16'h0001, 16'h0001, 16'h0001);
    chk(32'(events.launch), 32'h0);
    sm.accel(16'h0000, 16'h05dc, 16'h0000, 16'h0001, 16'h0001, 16'h0001);
    chk(32'(events.launch), 32'h1);
    wr(OFS_ALT_THRESH, 32'h0000_0200);
    rdc(OFS_ALT_THRESH, 32'h0000_0100, RESP_OKAY);
    chk(32'(irq), 32'h1);
    wr(OFS_INT_STAT, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    sm.accel(16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
    chk(32'(events.burnout), 32'h0);
    chk(32'(events.landing), 32'h0);
    sm.accel(16'h0000, 16'h0000, 16'h0000, 16'h0005, 16'h0005, 16'h0005);
    chk(32'(events.burnout), 32'h1);
    chk(32'(events.launch), 32'h1);
  endtask
  task automatic t_apogee();
    repeat (5) sm.press(24'h01_5f90);
    rdc(OFS_MIN_PRESS, 32'h0001_5f90, RESP_OKAY);
    repeat (2) sm.press(24'h01_5ff4);
    rdc(OFS_APO_CNT, 32'h2, RESP_OKAY);
    sm.press(24'h01_5ec8);
    rdc(OFS_APO_CNT, 32'h0, RESP_OKAY);
    repeat (4) sm.press(24'h01_6058);
    rdc(OFS_APO_CNT, 32'h4, RESP_OKAY);
    chk(32'(events.apogee), 32'h0);
    sm.press(24'h01_6058);
    chk(32'(events.apogee), 32'h1);
    sm.accel(16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
    chk(32'(events), 32'h1f);
    rdc(OFS_STATUS, 32'h0000_1f07, RESP_OKAY);
  endtask
  // second flight: descending threshold, landing by altitude
  task automatic t_descent();
    boot(1'b1);
    wr(OFS_CTRL, 32'h0000_0003);
    wr(OFS_ALT_THRESH, 32'h0000_0100);
    rdc(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    repeat (5) sm.press(ALT_REF_RST);
    sm.accel(16'h0000, 16'h05dc, 16'h0000, 16'h0001, 16'h0001, 16'h0001);
    repeat (5) sm.press(24'h01_7bcd);
    chk(32'(events.alt_reached), 32'h0);
    repeat (5) sm.press(24'h01_83cd);
    chk(32'(events.apogee), 32'h1);
    chk(32'(events.alt_reached), 32'h0);
    sm.accel(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk(32'(events.landing), 32'h0);
    repeat (5) sm.press(24'h01_89cd);
    chk(32'(events.alt_reached), 32'h1);
    chk(32'(events.landing), 32'h0);
    repeat (5) sm.press(ALT_REF_RST);
    chk(32'(events), 32'h1f);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    flight_strap = 1'b0;
    axi_req = '0;
    fail_count = 0;
    total_checks = 0;
    boot(1'b0);
    t_idle();
    boot(1'b1);
    t_launch();
    t_apogee();
    t_descent();
    complete_run();
  end
endmodule

bind fed_flight_event_detector fed_checker #(.ZERO_TOL_MG(ZERO_TOL_MG)) chk_u (
  .mclk(mclk), .rst_b(rst_b), .flight_strap(flight_strap), .press_in(press_in),
  .accel_in(accel_in), .axi_req(axi_req), .axi_rsp(axi_rsp), .events(events),
  .mode(mode), .flight_next_sel(flight_next_sel), .avg_valid(avg_valid), .irq(irq)
);
